// [hdl/cmp_mux_consts.svh]
`ifndef CMP_MUX_CONSTS_SVH
`define CMP_MUX_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_ONE   8'h01
`define OFS_STATUS_CTRL   8'h03
`define OFS_INPUT_SELECT  8'h05
`define OFS_IRQ_STATUS    8'h08
`define OFS_IRQ_CLEAR     8'h09
`define OFS_IRQ_ENABLE    8'h0A

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_PASS_THROUGH  7
`define BIT_SEL_RSVD      6
`define PLUS_SEL_HI       5
`define PLUS_SEL_LO       3
`define MINUS_SEL_HI      2
`define MINUS_SEL_LO      0
`define BIT_CMP_ENABLE    0
`define BIT_POL_FLIP      4
`define BIT_RISE_IEN      4
`define BIT_FALL_IEN      3
`define BIT_RISE_FLAG     2
`define BIT_FALL_FLAG     1
`define BIT_RESULT        0
`define BIT_EV_RISE       0
`define BIT_EV_FALL       1
`define BIT_EV_SHUT       2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_INPUT_SELECT  8'h00
`define RST_CONTROL_ONE   8'h00
`define RST_IRQ_ENABLE    3'h0

`endif

// [hdl/cmp_mux_pkg.sv]
package cmp_mux_pkg;
    typedef logic [2:0] source_sel_t;
    typedef logic [7:0] reg_byte_t;
endpackage

// [hdl/level_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Two-flop synchroniser
// ----------------------------------------------------------------
module level_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic reset_i,
    // Data
    input  wire logic async_i,
    output logic      sync_o
);
    logic [STAGES-1:0] chain_ff;

    // Fewer than two flops would let a metastable level reach the logic
    if (STAGES < 2) begin : g_stage_check
        $error("level_sync needs at least two stages");
    end

    // First stage is read only by the second
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain_ff[STAGES-1];
endmodule
`default_nettype wire

// [hdl/comparator_mux_and_edge_flags.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cmp_mux_consts.svh"

// Behaviour
// - Bit 7 of input select enables multiplexer pass-through mode.
// - Bit 6 of input select always reads zero; writes ignored.
// - Bits 5..3 choose plus input 0..7.
// - Bits 2..0 choose minus input 0..7.
// - Equal plus and minus selects shut the comparator down.
// - Raw result high when plus exceeds minus, low otherwise.
// - Polarity flip inverts result before edge detection and readback.
// - Falling edge sets fall flag; rising edge sets rise flag.
// - Rise and fall enables choose which flags raise interrupts.
// - Software reads current compare result through read-only status bit.
// - Edge flags clear only on writing one; zero leaves them.
// - Disabled comparator reads back the polarity flip bit; writes ignored.
// - Interrupt asserts while an enabled edge flag is set.
module comparator_mux_and_edge_flags
    import cmp_mux_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Analog core
    input  wire logic       compare_result_i,
    output logic      [2:0] plus_side_pin_o,
    output logic      [2:0] minus_side_pin_o,
    output logic            comparator_power_o,
    output logic            pass_through_enable_o,
    // Interrupts
    output logic            edge_irq_o,
    output logic            event_irq_o
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic        pass_through_enable_ff;
    source_sel_t plus_sel_ff;
    source_sel_t minus_sel_ff;
    logic        cmp_enable_ff;
    logic        output_polarity_flip_ff;
    logic        rise_irq_enable_ff;
    logic        fall_irq_enable_ff;
    logic        same_source;
    logic        cmp_active;

    // Input select register; bit 6 has no storage
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pass_through_enable_ff <= 1'(`RST_INPUT_SELECT >> `BIT_PASS_THROUGH);
            plus_sel_ff            <= 3'h0;
            minus_sel_ff           <= 3'h0;
        end else if (wr_i && hit(addr_i, `OFS_INPUT_SELECT)) begin
            pass_through_enable_ff <= wdata_i[`BIT_PASS_THROUGH];
            plus_sel_ff            <= wdata_i[`PLUS_SEL_HI:`PLUS_SEL_LO];
            minus_sel_ff           <= wdata_i[`MINUS_SEL_HI:`MINUS_SEL_LO];
        end
    end

    // Control register one: enable and polarity
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cmp_enable_ff           <= 1'b0;
            output_polarity_flip_ff <= 1'b0;
        end else if (wr_i && hit(addr_i, `OFS_CONTROL_ONE)) begin
            cmp_enable_ff           <= wdata_i[`BIT_CMP_ENABLE];
            output_polarity_flip_ff <= wdata_i[`BIT_POL_FLIP];
        end
    end

    // Edge interrupt enables in the status/control register
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rise_irq_enable_ff <= 1'b0;
            fall_irq_enable_ff <= 1'b0;
        end else if (wr_i && hit(addr_i, `OFS_STATUS_CTRL)) begin
            rise_irq_enable_ff <= wdata_i[`BIT_RISE_IEN];
            fall_irq_enable_ff <= wdata_i[`BIT_FALL_IEN];
        end
    end

    // Identical inputs would turn the comparator into a noise source
    assign same_source = (plus_sel_ff == minus_sel_ff);
    assign cmp_active  = cmp_enable_ff && !same_source;

    // ------------------------------------------------------------
    // Analog-side outputs, all registered
    // ------------------------------------------------------------
    logic [2:0] plus_pin_ff;
    logic [2:0] minus_pin_ff;
    logic       power_ff;
    logic       pass_ff;

    // Mux selects follow the register one cycle later
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            plus_pin_ff  <= 3'h0;
            minus_pin_ff <= 3'h0;
            power_ff     <= 1'b0;
            pass_ff      <= 1'b0;
        end else begin
            plus_pin_ff  <= plus_sel_ff;
            minus_pin_ff <= minus_sel_ff;
            power_ff     <= cmp_active;
            pass_ff      <= pass_through_enable_ff;
        end
    end

    assign plus_side_pin_o       = plus_pin_ff;
    assign minus_side_pin_o      = minus_pin_ff;
    assign comparator_power_o    = power_ff;
    assign pass_through_enable_o = pass_ff;

    // ------------------------------------------------------------
    // Result path
    // ------------------------------------------------------------
    logic raw_sync;
    logic result_now;
    logic result_prev_ff;
    logic active_prev_ff;
    logic rise_ev;
    logic fall_ev;

    // Analog result is asynchronous to the bus clock
    level_sync #(
        .STAGES (2)
    ) u_result_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i (compare_result_i),
        .sync_o  (raw_sync)
    );

    // Disabled core reads as the polarity bit
    assign result_now = cmp_active ? (raw_sync ^ output_polarity_flip_ff)
                                   : output_polarity_flip_ff;

    // Previous value for edge compare
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            result_prev_ff <= 1'b0;
            active_prev_ff <= 1'b0;
        end else begin
            result_prev_ff <= result_now;
            active_prev_ff <= cmp_active;
        end
    end

    // Edges only count while running and not in the first cycle after enable
    assign rise_ev = cmp_active && active_prev_ff && result_now && !result_prev_ff;
    assign fall_ev = cmp_active && active_prev_ff && !result_now && result_prev_ff;

    // ------------------------------------------------------------
    // Edge flags, write one to clear, set wins
    // ------------------------------------------------------------
    logic rise_flag_ff;
    logic fall_flag_ff;
    logic sc_wr;

    assign sc_wr = wr_i && hit(addr_i, `OFS_STATUS_CTRL);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rise_flag_ff <= 1'b0;
            fall_flag_ff <= 1'b0;
        end else begin
            if (rise_ev) begin
                rise_flag_ff <= 1'b1;
            end else if (sc_wr && wdata_i[`BIT_RISE_FLAG]) begin
                rise_flag_ff <= 1'b0;
            end
            if (fall_ev) begin
                fall_flag_ff <= 1'b1;
            end else if (sc_wr && wdata_i[`BIT_FALL_FLAG]) begin
                fall_flag_ff <= 1'b0;
            end
        end
    end

    // Edge interrupt line, registered
    logic edge_irq_ff;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            edge_irq_ff <= 1'b0;
        end else begin
            edge_irq_ff <= (rise_flag_ff && rise_irq_enable_ff) ||
                           (fall_flag_ff && fall_irq_enable_ff);
        end
    end

    assign edge_irq_o = edge_irq_ff;

    // ------------------------------------------------------------
    // Sticky event status, clear and enable registers
    // ------------------------------------------------------------
    logic [2:0] ev_status_ff;
    logic [2:0] ev_enable_ff;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic       shut_prev_ff;
    logic       event_irq_ff;

    // Shutdown event marks entry into the identical-input state
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            shut_prev_ff <= 1'b0;
        end else begin
            shut_prev_ff <= same_source;
        end
    end

    assign ev_set = {same_source && !shut_prev_ff, fall_ev, rise_ev};
    assign ev_clr = (wr_i && hit(addr_i, `OFS_IRQ_CLEAR)) ? wdata_i[2:0] : 3'h0;

    // One status bit per event, set beats clear
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ev
            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    ev_status_ff[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    ev_status_ff[gi] <= 1'b1;
                end else if (ev_clr[gi]) begin
                    ev_status_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ev_enable_ff <= `RST_IRQ_ENABLE;
        end else if (wr_i && hit(addr_i, `OFS_IRQ_ENABLE)) begin
            ev_enable_ff <= wdata_i[2:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            event_irq_ff <= 1'b0;
        end else begin
            event_irq_ff <= |(ev_status_ff & ev_enable_ff);
        end
    end

    assign event_irq_o = event_irq_ff;

    // ------------------------------------------------------------
    // Read data, valid the cycle after the strobe
    // ------------------------------------------------------------
    reg_byte_t rdata_ff;
    reg_byte_t nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_i) begin
            if (hit(addr_i, `OFS_INPUT_SELECT)) begin
                nxt_rdata = {pass_through_enable_ff, 1'b0, plus_sel_ff, minus_sel_ff};
            end else if (hit(addr_i, `OFS_CONTROL_ONE)) begin
                nxt_rdata[`BIT_CMP_ENABLE] = cmp_enable_ff;
                nxt_rdata[`BIT_POL_FLIP]   = output_polarity_flip_ff;
            end else if (hit(addr_i, `OFS_STATUS_CTRL)) begin
                nxt_rdata[`BIT_RISE_IEN]  = rise_irq_enable_ff;
                nxt_rdata[`BIT_FALL_IEN]  = fall_irq_enable_ff;
                nxt_rdata[`BIT_RISE_FLAG] = rise_flag_ff;
                nxt_rdata[`BIT_FALL_FLAG] = fall_flag_ff;
                nxt_rdata[`BIT_RESULT]    = result_now;
            end else if (hit(addr_i, `OFS_IRQ_STATUS)) begin
                nxt_rdata[2:0] = ev_status_ff;
            end else if (hit(addr_i, `OFS_IRQ_ENABLE)) begin
                nxt_rdata[2:0] = ev_enable_ff;
            end
        end
    end

    // Unmapped and write-only addresses read as zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rsvd_bit_zero: assert property (@(posedge clock_i) disable iff (reset_i)
        $past(rd_i) && $past(addr_i) == `OFS_INPUT_SELECT |-> rdata_o[6] == 1'b0)
        else $error("reserved select bit read nonzero");

    a_pass_follow: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_i && addr_i == `OFS_INPUT_SELECT |-> ##2 pass_through_enable_o == $past(wdata_i[7], 2))
        else $error("pass-through output did not follow write");

    a_plus_select: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_i && addr_i == `OFS_INPUT_SELECT |-> ##2 plus_side_pin_o == $past(wdata_i[5:3], 2))
        else $error("plus select wrong");

    a_minus_select: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_i && addr_i == `OFS_INPUT_SELECT |-> ##2 minus_side_pin_o == $past(wdata_i[2:0], 2))
        else $error("minus select wrong");

    a_same_shut: assert property (@(posedge clock_i) disable iff (reset_i)
        plus_sel_ff == minus_sel_ff |=> !comparator_power_o)
        else $error("comparator powered with identical inputs");

    a_readback_off: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_i && addr_i == `OFS_STATUS_CTRL && !cmp_active
        |=> rdata_o[0] == $past(output_polarity_flip_ff))
        else $error("disabled readback not polarity bit");

    a_rise_sets: assert property (@(posedge clock_i) disable iff (reset_i)
        cmp_active && $past(cmp_active) && $rose(result_now) |=> rise_flag_ff)
        else $error("rising edge did not set flag");

    a_fall_sets: assert property (@(posedge clock_i) disable iff (reset_i)
        cmp_active && $past(cmp_active) && $fell(result_now) |=> fall_flag_ff)
        else $error("falling edge did not set flag");

    a_flag_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        rise_flag_ff && !(sc_wr && wdata_i[2]) |=> rise_flag_ff)
        else $error("rise flag lost without clear");

    a_irq_level: assert property (@(posedge clock_i) disable iff (reset_i)
        ((rise_flag_ff && rise_irq_enable_ff) || (fall_flag_ff && fall_irq_enable_ff))
        |=> edge_irq_o)
        else $error("edge interrupt not raised");

endmodule
`default_nettype wire

// [testbench/analog_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Analog comparator core with eight input sources
// ----------------------------------------------------------------
module analog_core_model (
    // Mux selects and power from the block
    input  wire logic [2:0]      plus_side_pin_i,
    input  wire logic [2:0]      minus_side_pin_i,
    input  wire logic            power_i,
    // Source levels, one byte each, set by the bench
    input  wire logic [7:0][7:0] level_i,
    // Raw result back to the block
    output logic                 compare_result_o
);
    // Unpowered core drives 0; powered core compares the selected sources
    always_comb begin
        if (!power_i) begin
            compare_result_o = 1'b0;
        end else begin
            compare_result_o = level_i[plus_side_pin_i] > level_i[minus_side_pin_i];
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_comparator_mux_and_edge_flags.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cmp_mux_consts.svh"
module tb_comparator_mux_and_edge_flags;
    import cmp_mux_pkg::*;
    logic            clock_i;
    logic            reset_i;
    logic [7:0]      addr_i;
    logic [7:0]      wdata_i;
    logic            wr_i;
    logic            rd_i;
    logic [7:0]      rdata_o;
    logic            compare_result_i;
    logic [2:0]      plus_side_pin_o;
    logic [2:0]      minus_side_pin_o;
    logic            comparator_power_o;
    logic            pass_through_enable_o;
    logic            edge_irq_o;
    logic            event_irq_o;
    logic [7:0][7:0] level;
    int              n_fail;
    int              checks_done;
    logic [31:0]     seed;
    reg_byte_t       d;
    reg_byte_t       w;

    comparator_mux_and_edge_flags dut_u (
        .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .compare_result_i(compare_result_i),
        .plus_side_pin_o(plus_side_pin_o), .minus_side_pin_o(minus_side_pin_o),
        .comparator_power_o(comparator_power_o), .pass_through_enable_o(pass_through_enable_o),
        .edge_irq_o(edge_irq_o), .event_irq_o(event_irq_o));

    analog_core_model core_u (
        .plus_side_pin_i(plus_side_pin_o), .minus_side_pin_i(minus_side_pin_o),
        .power_i(comparator_power_o), .level_i(level), .compare_result_o(compare_result_i));

    // ----------------------------------------------------------------
    // Clock, shared tasks and expectation helpers
    // ----------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Xorshift keeps the run repeatable without simulator seeding
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Reserved bit 6 of the select register never reads back
    function automatic reg_byte_t exp_select(input reg_byte_t v);
        return v & 8'h_BF;
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output reg_byte_t v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #(40 * 20000);
        n_fail++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        n_fail = 0;
        checks_done = 0;
        seed = 32'd57991;
        addr_i = 8'h_00;
        wdata_i = 8'h_00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        level = '0;
        reset_i = 1'b1;
        repeat (4) @(posedge clock_i);
        reset_i <= 1'b0;
        // Reset values, write-only and unmapped places read zero
        reg_read(`OFS_INPUT_SELECT, d); check("sel_rst", d, `RST_INPUT_SELECT);
        reg_read(`OFS_CONTROL_ONE, d); check("ctl_rst", d, `RST_CONTROL_ONE);
        reg_read(`OFS_STATUS_CTRL, d); check("stat_rst", d, 8'h_00);
        reg_read(`OFS_IRQ_CLEAR, d); check("clr_rd", d, 8'h_00);
        reg_read(8'h_7F, d); check("unmapped", d, 8'h_00);
        // Every select code on both sides, then random bytes with corners
        for (int i = 0; i < 8; i++) level[i] = 8'(i * 20 + 10);
        reg_write(`OFS_CONTROL_ONE, 8'h_01);
        for (int i = 0; i < 24; i++) begin
            if (i < 8) begin
                w = {2'b00, 3'(i), 3'(7 - i)};
            end else if (i == 8) begin
                w = 8'h_FF;
            end else if (i == 9) begin
                w = 8'h_40;
            end else begin
                seed = xorshift(seed);
                w = seed[7:0];
            end
            reg_write(`OFS_INPUT_SELECT, w);
            wait_cyc(1);
            check("plus_sel", {5'b0, plus_side_pin_o}, {5'b0, w[5:3]});
            check("minus_sel", {5'b0, minus_side_pin_o}, {5'b0, w[2:0]});
            check("pass", {7'b0, pass_through_enable_o}, {7'b0, w[7]});
            check("power", {7'b0, comparator_power_o}, {7'b0, w[5:3] != w[2:0]});
            reg_read(`OFS_INPUT_SELECT, d); check("sel_rd", d, exp_select(w));
        end
        // Plus 1 over minus 0: result high, edges into flags and interrupt
        level[1] = 8'd200; level[0] = 8'd100;
        reg_write(`OFS_INPUT_SELECT, 8'h_08);
        wait_cyc(6);
        reg_write(`OFS_STATUS_CTRL, 8'h_1E);
        wait_cyc(2);
        reg_read(`OFS_STATUS_CTRL, d); check("stat_hi", d, 8'h_19);
        check("irq_idle", {7'b0, edge_irq_o}, 8'h_00);
        @(posedge clock_i); level[1] <= 8'd50;
        wait_cyc(5);
        reg_read(`OFS_STATUS_CTRL, d); check("stat_fall", d, 8'h_1A);
        check("irq_fall", {7'b0, edge_irq_o}, 8'h_01);
        reg_write(`OFS_STATUS_CTRL, 8'h_18);
        reg_read(`OFS_STATUS_CTRL, d); check("w0_keep", d, 8'h_1A);
        @(posedge clock_i); level[1] <= 8'd200;
        wait_cyc(5);
        reg_read(`OFS_STATUS_CTRL, d); check("stat_rise", d, 8'h_1F);
        reg_write(`OFS_STATUS_CTRL, 8'h_1A);
        reg_read(`OFS_STATUS_CTRL, d); check("clr_fall", d, 8'h_1D);
        reg_write(`OFS_STATUS_CTRL, 8'h_08);
        wait_cyc(2);
        check("irq_mask", {7'b0, edge_irq_o}, 8'h_00);
        // Polarity flip turns the high result into a falling edge
        reg_write(`OFS_CONTROL_ONE, 8'h_11);
        wait_cyc(5);
        reg_read(`OFS_STATUS_CTRL, d); check("flip", d, 8'h_0E);
        check("irq_flip", {7'b0, edge_irq_o}, 8'h_01);
        // Event status, enable and clear registers
        reg_write(`OFS_IRQ_CLEAR, 8'h_07);
        reg_read(`OFS_IRQ_STATUS, d); check("ev_clr", d, 8'h_00);
        @(posedge clock_i); level[1] <= 8'd50;
        wait_cyc(5);
        reg_read(`OFS_IRQ_STATUS, d); check("ev_rise", d, 8'h_01);
        check("ev_masked", {7'b0, event_irq_o}, 8'h_00);
        reg_write(`OFS_IRQ_ENABLE, 8'h_05);
        wait_cyc(2);
        check("ev_irq", {7'b0, event_irq_o}, 8'h_01);
        reg_read(`OFS_IRQ_ENABLE, d); check("ev_en_rd", d, 8'h_05);
        reg_write(`OFS_IRQ_CLEAR, 8'h_01);
        wait_cyc(2);
        reg_read(`OFS_IRQ_STATUS, d); check("ev_w1c", d, 8'h_00);
        check("ev_irq_off", {7'b0, event_irq_o}, 8'h_00);
        // Equal selects shut the core down and raise the shutdown event
        reg_write(`OFS_INPUT_SELECT, 8'h_09);
        wait_cyc(3);
        check("shut_pwr", {7'b0, comparator_power_o}, 8'h_00);
        reg_read(`OFS_IRQ_STATUS, d); check("ev_shut", d & 8'h_04, 8'h_04);
        check("ev_irq_shut", {7'b0, event_irq_o}, 8'h_01);
        // Disabled core reads back the flip bit and ignores result writes
        reg_write(`OFS_INPUT_SELECT, 8'h_08);
        reg_write(`OFS_CONTROL_ONE, 8'h_10);
        reg_write(`OFS_STATUS_CTRL, 8'h_00);
        wait_cyc(4);
        reg_read(`OFS_STATUS_CTRL, d); check("dis_flip", d & 8'h_01, 8'h_01);
        reg_write(`OFS_CONTROL_ONE, 8'h_00);
        reg_write(`OFS_STATUS_CTRL, 8'h_01);
        wait_cyc(4);
        reg_read(`OFS_STATUS_CTRL, d); check("dis_norm", d & 8'h_01, 8'h_00);
        conclude();
    end
endmodule
`default_nettype wire
